// File: logic/ldc_defines.svh
// Constants for the loop detector switch configuration loader
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH
// Clock and time base
`define LDC_CLK_NS         10
`define LDC_MS_NS          1000000
`define LDC_MS_CYCLES      (`LDC_MS_NS / `LDC_CLK_NS)
`define LDC_MIN_MS         60000
// Timing defaults
`define LDC_PULSE_MS       250
`define LDC_PULSE_LONG_MS  500
`define LDC_DELAY_MS       2500
`define LDC_PPC1_MIN       5
`define LDC_PPC2_MIN       25
`define LDC_PPC3_MIN       35
`define LDC_WARM_STEP_MS   250
`define LDC_TUNE_DWELL_MS  100
// Switch bank one, general layout
`define LDC_G1_EN_LSB      0
`define LDC_G1_DIR_AB      4
`define LDC_G1_DIR_CD      5
// Switch bank two, general layout
`define LDC_G2_FILTER      0
`define LDC_G2_BLINK       1
`define LDC_G2_WARM        2
`define LDC_G2_TUNE        3
`define LDC_G2_REV_LSB     4
// Channel word: bank one in [7:0], bank two in [15:8]
`define LDC_C_ALT_LSB      0
`define LDC_C_PPC1         2
`define LDC_C_PPC2         3
`define LDC_C_PRES         4
`define LDC_C_EXT          5
`define LDC_C_DLY          6
`define LDC_C_INV          7
`define LDC_FACTORY_CFG    16'h0010
`define LDC_SENS_TGT_RST   12'h_fff
// Register byte offsets
`define LDC_A_STATUS       8'h00
`define LDC_A_GENERAL      8'h04
`define LDC_A_PULSE        8'h08
`define LDC_A_DELAY        8'h0c
`define LDC_A_PPC1         8'h10
`define LDC_A_PPC2         8'h14
`define LDC_A_PPC3         8'h18
`define LDC_A_OUTPUTS      8'h1c
`define LDC_A_SENS         8'h20
`define LDC_A_CH0          8'h30
`define LDC_A_CH3          8'h3c
// AXI responses
`define LDC_RESP_OKAY      2'b00
`define LDC_RESP_DECERR    2'b11
`endif

// File: logic/ldc_pkg.sv
// Types for the loop detector switch configuration loader
`default_nettype none
package ldc_pkg;
   typedef enum logic [4:0] {
      LDC_ST_CAPTURE  = 5'b00001,
      LDC_ST_FACTORY  = 5'b00010,
      LDC_ST_WAIT_REL = 5'b00100,
      LDC_ST_SETUP    = 5'b01000,
      LDC_ST_RUN      = 5'b10000
   } ldc_state_e;
   typedef logic [15:0] ldc_cfg_t;
endpackage : ldc_pkg
`default_nettype wire

// File: logic/ldc_top.sv
// Switch capture, per-channel setup memory and relay output behaviour
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
`include "ldc_defines.svh"
// Overview of operation
// - General switches are sampled only right after reset; later changes are ignored.
// - Bank one positions 1 to 4 enable channels A, B, C, D.
// - Bank one position 5 pairs A and B and forces both enabled.
// - Bank one position 6 pairs C and D and forces both enabled.
// - Bank two position 1 turns on extra filtering for all channels.
// - Bank two position 2 requests frequency blinking at startup.
// - Bank two position 3 starts sensitivity at minimum, ramping to target.
// - Bank two position 4 sweeps alternative frequencies and keeps the quietest.
// - Bank two position 5: with A and B paired, relay A fires only on abandoned A-to-B pass.
// - Bank two position 6: with A and B paired, relay B fires only on abandoned B-to-A pass.
// - Bank two positions 7, 8 do the same for relays C and D when C and D are paired.
// - Button held at reset enters setup; stored channel word shows while still held.
// - In setup, pressing the channel button saves switches and shows them.
// - Another button selects that channel; setup ends only by a reset.
// - Channel positions 1 and 2 choose the alternative frequency shift.
// - Positions 3, 4 cancel standing detection after 5, 25, 35 minutes.
// - Position 5 gives presence output; clear gives one pulse per detection.
// - Position 6 stretches the pulse from 250 ms to 500 ms.
// - Position 7 delays activation 2.5 s; in pulse mode no pulse occurs.
// - Position 8 inverts the channel output.
// - An inactive, non-inverted output is left undriven.
// - All four buttons held at reset restore factory channel words.
module ldc_top
   import ldc_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `LDC_MS_CYCLES
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready,
   input  wire logic [7:0]  switch_bank_one,
   input  wire logic [7:0]  switch_bank_two,
   input  wire logic [3:0]  chan_button,
   input  wire logic [3:0]  vehicle_detect,
   input  wire logic [3:0]  pass_abandon,
   input  wire logic [7:0]  noise_level,
   output var  logic [15:0] bar_graph,
   output var  logic [3:0]  relay_out,
   output var  logic [3:0]  relay_oe,
   output var  logic [3:0]  chan_enable,
   output var  logic        dir_pair_ab,
   output var  logic        dir_pair_cd,
   output var  logic        extra_filter,
   output var  logic        blink_freq,
   output var  logic [11:0] sensitivity,
   output var  logic [7:0]  alt_freq,
   output var  logic        setup_mode
);
   if (MS_CYCLES < 2 || MS_CYCLES > 131072) begin : g_chk
      $error("MS_CYCLES must be 2 to 131072");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [1:0] first_button(input logic [3:0] b);
      first_button = b[0] ? 2'd0 : b[1] ? 2'd1 : b[2] ? 2'd2 : 2'd3;
   endfunction : first_button

   ldc_state_e  state_q;
   ldc_cfg_t    cfg_mem_q [4];
   logic [1:0]  sel_q;
   logic [3:0]  btn_d1_q;
   logic [3:0]  btn_rise;
   logic [7:0]  gen_one_q;
   logic [7:0]  gen_two_q;
   logic [15:0] pulse_s_q;
   logic [15:0] pulse_l_q;
   logic [23:0] delay_ms_q;
   logic [23:0] ppc_ms_q [3];
   logic [11:0] sens_tgt_q;
   logic [16:0] ms_cnt_q;
   logic        tick_q;
   logic [23:0] tmr_q [4];
   logic [15:0] pcnt_q [4];
   logic [3:0]  ppc_done_q;
   logic [3:0]  det_d1_q;
   logic [3:0]  active_q;

   assign btn_rise = chan_button & ~btn_d1_q;

   ////////////////////////////////////////////////////////////////////////////
   // Startup and setup sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q  <= LDC_ST_CAPTURE;
         sel_q    <= 2'd0;
         btn_d1_q <= 4'h0;
         setup_mode <= 1'b0;
      end
      else begin
         btn_d1_q <= chan_button;
         setup_mode <= state_q[3] | state_q[2];
         unique case (state_q)
            LDC_ST_CAPTURE:
            begin
               if (&chan_button)
                  state_q <= LDC_ST_FACTORY;
               else if (|chan_button)
               begin
                  sel_q   <= first_button(chan_button);
                  state_q <= LDC_ST_WAIT_REL;
               end
               else
                  state_q <= LDC_ST_RUN;
            end
            LDC_ST_FACTORY:
               state_q <= LDC_ST_RUN;
            LDC_ST_WAIT_REL:
               if (chan_button == 4'h0)
                  state_q <= LDC_ST_SETUP;
            LDC_ST_SETUP:
               if (|(btn_rise & ~(4'h1 << sel_q)))
               begin
                  sel_q   <= first_button(btn_rise & ~(4'h1 << sel_q));
                  state_q <= LDC_ST_WAIT_REL;
               end
            LDC_ST_RUN:
               state_q <= LDC_ST_RUN;
         endcase
      end
   end

   // Channel words are kept across resets
   always_ff @(posedge aclk) begin
      if (state_q == LDC_ST_FACTORY)
         for (int c = 0; c < 4; c++)
            cfg_mem_q[c] <= `LDC_FACTORY_CFG;
      else if (state_q == LDC_ST_SETUP && btn_rise[sel_q])
         cfg_mem_q[sel_q] <= {switch_bank_two, switch_bank_one};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         bar_graph <= 16'h0000;
      else if (setup_mode)
         bar_graph <= cfg_mem_q[sel_q];
      else
         bar_graph <= 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // General configuration capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gen_one_q <= 8'h00;
         gen_two_q <= 8'h00;
      end
      else if (state_q == LDC_ST_CAPTURE) begin
         gen_one_q <= switch_bank_one & 8'h3f;
         gen_two_q <= switch_bank_two;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_enable  <= 4'h0;
         dir_pair_ab  <= 1'b0;
         dir_pair_cd  <= 1'b0;
         extra_filter <= 1'b0;
         blink_freq   <= 1'b0;
      end
      else begin
         chan_enable  <= gen_one_q[`LDC_G1_EN_LSB +: 4]
                       | {4{gen_one_q[`LDC_G1_DIR_CD]}} & 4'hc
                       | {4{gen_one_q[`LDC_G1_DIR_AB]}} & 4'h3;
         dir_pair_ab  <= gen_one_q[`LDC_G1_DIR_AB];
         dir_pair_cd  <= gen_one_q[`LDC_G1_DIR_CD];
         extra_filter <= gen_two_q[`LDC_G2_FILTER];
         blink_freq   <= gen_two_q[`LDC_G2_BLINK] && state_q == LDC_ST_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_cnt_q <= 17'd0;
         tick_q   <= 1'b0;
      end
      else begin
         tick_q   <= (ms_cnt_q == 17'(MS_CYCLES - 1));
         ms_cnt_q <= (ms_cnt_q == 17'(MS_CYCLES - 1)) ? 17'd0 : ms_cnt_q + 17'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Warm-up ramp and frequency sweep
   logic [15:0] warm_cnt_q;
   logic        tune_busy_q;
   logic [1:0]  tune_code_q;
   logic [1:0]  tune_best_q;
   logic [7:0]  tune_min_q;
   logic [15:0] dwell_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sensitivity <= 12'h000;
         warm_cnt_q  <= 16'd0;
      end
      else if (state_q == LDC_ST_CAPTURE)
         sensitivity <= switch_bank_two[`LDC_G2_WARM] ? 12'h000 : sens_tgt_q;
      else if (tick_q) begin
         warm_cnt_q <= (warm_cnt_q == 16'(`LDC_WARM_STEP_MS - 1)) ? 16'd0 : warm_cnt_q + 16'd1;
         if (warm_cnt_q == 16'(`LDC_WARM_STEP_MS - 1))
            for (int c = 0; c < 4; c++)
               if (sensitivity[c*3 +: 3] < sens_tgt_q[c*3 +: 3])
                  sensitivity[c*3 +: 3] <= sensitivity[c*3 +: 3] + 3'd1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tune_busy_q <= 1'b0;
         tune_code_q <= 2'd0;
         tune_best_q <= 2'd0;
         tune_min_q  <= 8'hff;
         dwell_q     <= 16'd0;
      end
      else if (state_q == LDC_ST_CAPTURE)
         tune_busy_q <= switch_bank_two[`LDC_G2_TUNE];
      else if (tune_busy_q && tick_q) begin
         dwell_q <= dwell_q + 16'd1;
         if (dwell_q == 16'(`LDC_TUNE_DWELL_MS - 1)) begin
            dwell_q <= 16'd0;
            if (noise_level < tune_min_q) begin
               tune_min_q  <= noise_level;
               tune_best_q <= tune_code_q;
            end
            tune_code_q <= tune_code_q + 2'd1;
            if (tune_code_q == 2'd3)
               tune_busy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         alt_freq <= 8'h00;
      else
         for (int c = 0; c < 4; c++)
            alt_freq[c*2 +: 2] <= tune_busy_q ? tune_code_q :
                                  gen_two_q[`LDC_G2_TUNE] ? tune_best_q :
                                  cfg_mem_q[c][`LDC_C_ALT_LSB +: 2];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel output behaviour
   function automatic logic [23:0] ppc_limit(input ldc_cfg_t w);
      unique case ({w[`LDC_C_PPC2], w[`LDC_C_PPC1]})
         2'b01:   ppc_limit = ppc_ms_q[0];
         2'b10:   ppc_limit = ppc_ms_q[1];
         default: ppc_limit = ppc_ms_q[2];
      endcase
   endfunction : ppc_limit

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int c = 0; c < 4; c++) begin
            tmr_q[c]  <= 24'd0;
            pcnt_q[c] <= 16'd0;
         end
         ppc_done_q <= 4'h0;
         det_d1_q   <= 4'h0;
         active_q   <= 4'h0;
      end
      else begin
         det_d1_q <= vehicle_detect;
         for (int c = 0; c < 4; c++) begin
            logic rev_only;
            logic [23:0] lim;
            rev_only = gen_two_q[`LDC_G2_REV_LSB + c] &&
                       (c < 2 ? gen_one_q[`LDC_G1_DIR_AB] : gen_one_q[`LDC_G1_DIR_CD]);
            lim = ppc_limit(cfg_mem_q[c]);
            if (!vehicle_detect[c]) begin
               tmr_q[c]      <= 24'd0;
               ppc_done_q[c] <= 1'b0;
            end
            else if (tick_q && tmr_q[c] != 24'hff_ffff)
               tmr_q[c] <= tmr_q[c] + 24'd1;
            if (vehicle_detect[c] && (cfg_mem_q[c][`LDC_C_PPC1] | cfg_mem_q[c][`LDC_C_PPC2])
                && tmr_q[c] >= lim)
               ppc_done_q[c] <= 1'b1;
            if (rev_only ? pass_abandon[c] :
                (vehicle_detect[c] && !det_d1_q[c] && !cfg_mem_q[c][`LDC_C_DLY]))
               pcnt_q[c] <= cfg_mem_q[c][`LDC_C_EXT] ? pulse_l_q : pulse_s_q;
            else if (tick_q && pcnt_q[c] != 16'd0)
               pcnt_q[c] <= pcnt_q[c] - 16'd1;
            if (state_q != LDC_ST_RUN || !chan_enable[c])
               active_q[c] <= 1'b0;
            else if (!rev_only && cfg_mem_q[c][`LDC_C_PRES])
               active_q[c] <= vehicle_detect[c] && !ppc_done_q[c] &&
                              (!cfg_mem_q[c][`LDC_C_DLY] || tmr_q[c] >= delay_ms_q);
            else
               active_q[c] <= pcnt_q[c] != 16'd0;
         end
      end
   end

   // Open collector: drive low when asserted, float otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         relay_out <= 4'h0;
         relay_oe  <= 4'h0;
      end
      else begin
         relay_out <= 4'h0;
         for (int c = 0; c < 4; c++)
            relay_oe[c] <= active_q[c] ^ (cfg_mem_q[c][`LDC_C_INV] &&
                           state_q == LDC_ST_RUN && chan_enable[c]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic       aw_hold_q;
   logic       w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        do_write;

   assign do_write = aw_hold_q && w_hold_q && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `LDC_RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end
      else begin
         awready <= !aw_hold_q && !awready && awvalid;
         wready  <= !w_hold_q && !wready && wvalid;
         if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= (aw_addr_q <= `LDC_A_CH3 && aw_addr_q[1:0] == 2'b00)
                         ? `LDC_RESP_OKAY : `LDC_RESP_DECERR;
         end
         else if (bready)
            bvalid <= 1'b0;
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int b = 0; b < 4; b++)
         old[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      merge = old;
   endfunction : merge

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_s_q   <= 16'(`LDC_PULSE_MS);
         pulse_l_q   <= 16'(`LDC_PULSE_LONG_MS);
         delay_ms_q  <= 24'(`LDC_DELAY_MS);
         ppc_ms_q[0] <= 24'(`LDC_PPC1_MIN * `LDC_MIN_MS);
         ppc_ms_q[1] <= 24'(`LDC_PPC2_MIN * `LDC_MIN_MS);
         ppc_ms_q[2] <= 24'(`LDC_PPC3_MIN * `LDC_MIN_MS);
         sens_tgt_q  <= `LDC_SENS_TGT_RST;
      end
      else if (do_write) begin
         unique case (aw_addr_q)
            `LDC_A_PULSE: {pulse_l_q, pulse_s_q} <=
                             merge({pulse_l_q, pulse_s_q}, w_data_q, w_strb_q);
            `LDC_A_DELAY: delay_ms_q <= 24'(merge({8'h00, delay_ms_q}, w_data_q, w_strb_q));
            `LDC_A_PPC1: ppc_ms_q[0] <= 24'(merge({8'h00, ppc_ms_q[0]}, w_data_q, w_strb_q));
            `LDC_A_PPC2: ppc_ms_q[1] <= 24'(merge({8'h00, ppc_ms_q[1]}, w_data_q, w_strb_q));
            `LDC_A_PPC3: ppc_ms_q[2] <= 24'(merge({8'h00, ppc_ms_q[2]}, w_data_q, w_strb_q));
            `LDC_A_SENS: sens_tgt_q <= 12'(merge({20'h0_0000, sens_tgt_q}, w_data_q, w_strb_q));
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `LDC_RESP_OKAY;
      end
      else begin
         arready <= !arready && !rvalid && arvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= `LDC_RESP_OKAY;
            unique case (araddr)
               `LDC_A_STATUS:  rdata <= {18'h0_0000, tune_best_q, tune_busy_q,
                                        sel_q, 4'h0, state_q};
               `LDC_A_GENERAL: rdata <= {16'h0000, gen_two_q, gen_one_q};
               `LDC_A_PULSE:   rdata <= {pulse_l_q, pulse_s_q};
               `LDC_A_DELAY:   rdata <= {8'h00, delay_ms_q};
               `LDC_A_PPC1:    rdata <= {8'h00, ppc_ms_q[0]};
               `LDC_A_PPC2:    rdata <= {8'h00, ppc_ms_q[1]};
               `LDC_A_PPC3:    rdata <= {8'h00, ppc_ms_q[2]};
               `LDC_A_OUTPUTS: rdata <= {20'h0_0000, ppc_done_q, vehicle_detect, active_q};
               `LDC_A_SENS:    rdata <= {8'h00, sensitivity, sens_tgt_q};
               default:
               begin
                  if (araddr >= `LDC_A_CH0 && araddr <= `LDC_A_CH3 && araddr[1:0] == 2'b00)
                     rdata <= {16'h0000, cfg_mem_q[araddr[3:2]]};
                  else
                  begin
                     rdata <= 32'h0000_0000;
                     rresp <= `LDC_RESP_DECERR;
                  end
               end
            endcase
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end
endmodule : ldc_top
`default_nettype wire

// File: tb/ldc_relay_load.sv
// Open-collector relay loads with pull-ups on the output lines
`default_nettype none
module ldc_relay_load
(
   input  wire logic [3:0] relay_out,
   input  wire logic [3:0] relay_oe,
   output var  logic [3:0] relay_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released lines float up to the pull-up level
   always_comb
   begin
      for (int i = 0; i < 4; i++) relay_line[i] = relay_oe[i] ? relay_out[i] : 1'b1;
   end
endmodule : ldc_relay_load
`default_nettype wire

// File: tb/ldc_top_sva.sv
// Checker for handshakes, channel pairing and setup behaviour of the loader
`default_nettype none
module ldc_top_sva
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awready,
   input wire logic        bvalid,
   input wire logic [1:0]  bresp,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic [31:0] rdata,
   input wire logic        rready,
   input wire logic [3:0]  chan_enable,
   input wire logic        dir_pair_ab,
   input wire logic        dir_pair_cd,
   input wire logic        setup_mode,
   input wire logic [3:0]  relay_out,
   input wire logic [3:0]  relay_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [2:0] run_q;
   // Edges since reset release
   always_ff @(posedge aclk)
   begin
      if (!aresetn) run_q <= 3'h0;
      else if (run_q != 3'h6) run_q <= run_q + 3'h1;
   end
   bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
   rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped before rready");
   awready_pulse_a: assert property (awready |=> !awready)
      else $error("awready held longer than one cycle");
   arready_cause_a: assert property (arready |-> $past(arvalid))
      else $error("arready without a read request");
   pair_ab_a: assert property (dir_pair_ab |-> &chan_enable[1:0])
      else $error("pair A B not forcing both enabled");
   pair_cd_a: assert property (dir_pair_cd |-> &chan_enable[3:2])
      else $error("pair C D not forcing both enabled");
   en_frozen_a: assert property (run_q == 3'h6 |-> $stable(chan_enable) && $stable(dir_pair_ab))
      else $error("general settings changed without reset");
   setup_stay_a: assert property (setup_mode |=> setup_mode)
      else $error("setup left without reset");
   relay_low_a: assert property (relay_out == 4'h0 && (!setup_mode || relay_oe == 4'h0))
      else $error("relay driven wrongly");
   cover property (setup_mode);
   cover property (dir_pair_cd);
   cover property (relay_oe[1]);
endmodule : ldc_top_sva
bind ldc_top ldc_top_sva ldc_top_sva_i (.aclk, .aresetn, .awready, .bvalid, .bresp, .bready,
   .arvalid, .arready, .rvalid, .rdata, .rready, .chan_enable, .dir_pair_ab, .dir_pair_cd,
   .setup_mode, .relay_out, .relay_oe);
`default_nettype wire

// File: tb/ldc_top_test.sv
// Self-checking bench for the switch configuration loader
`default_nettype none
module ldc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 4;
   localparam logic [7:0] G1 [4] = '{8'h05, 8'h1a, 8'h23, 8'hc8};
   localparam logic [7:0] G2 [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic        bvalid, arready, rvalid, setup_mode, dir_pair_ab, dir_pair_cd;
   logic        extra_filter, blink_freq;
   logic [7:0]  awaddr, araddr, switch_bank_one, switch_bank_two;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp;
   logic [3:0]  chan_button, vehicle_detect, relay_out, relay_oe, relay_line, chan_enable;
   logic [15:0] bar_graph;
   logic [3:0]  pass_abandon;
   int          fails, n_tests, cyc;
   ldc_top #(.MS_CYCLES(MS)) ldc_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .switch_bank_one, .switch_bank_two,
      .chan_button, .vehicle_detect, .pass_abandon, .noise_level(8'h00), .bar_graph,
      .relay_out, .relay_oe, .chan_enable, .dir_pair_ab, .dir_pair_cd, .extra_filter,
      .blink_freq, .sensitivity(), .alt_freq(), .setup_mode);
   ldc_relay_load ldc_relay_load_i (.relay_out, .relay_oe, .relay_line);
   always #5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] s, input logic [31:0] e, input string nm);
      n_tests++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task end_sim;
      $display("Checks %0d, errors %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         fails++;
         end_sim;
      end
   end
   task rst(input logic [7:0] s1, input logic [7:0] s2, input logic [3:0] b);
      @(posedge aclk);
      aresetn <= 1'b0;
      switch_bank_one <= s1;
      switch_bank_two <= s2;
      chan_button <= b;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask : rst
   task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check(bresp, er, "bresp");
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rready <= 1'b0;
      check(rresp, er, "rresp");
   endtask : axi_rd
   ////////////////////////////////////////////////////////////////////////////////
   task t_general;
      logic [3:0] en;
      for (int i = 0; i < 4; i++)
      begin
         rst(G1[i], G2[i], 4'h0);
         en = G1[i][3:0] | {{2{G1[i][5]}}, {2{G1[i][4]}}};
         check(chan_enable, en, "chan_enable");
         check({dir_pair_cd, dir_pair_ab}, G1[i][5:4], "pairing");
         check({blink_freq, extra_filter}, G2[i][1:0], "filter blink");
         axi_rd(8'h04, 2'b00);
         check(d, {16'h0000, G2[i], 2'b00, G1[i][5:0]}, "general word");
         switch_bank_one <= ~G1[i];
         switch_bank_two <= ~G2[i];
         repeat (4) @(posedge aclk);
         check(chan_enable, en, "frozen enables");
      end
   endtask : t_general
   task t_regs;
      axi_rd(8'h08, 2'b00);
      check(d, 32'h01f4_00fa, "pulse reset");
      axi_wr(8'h08, 32'h0003_0002, 2'b00);
      axi_rd(8'h08, 2'b00);
      check(d, 32'h0003_0002, "pulse write");
      axi_wr(8'h04, 32'hffff_ffff, 2'b00);
      axi_rd(8'h04, 2'b00);
      check(d, 32'h0000_0308, "general read only");
      axi_wr(8'h44, 32'h0000_0001, 2'b11);
      axi_rd(8'h44, 2'b11);
      check(d, 32'h0000_0000, "unmapped data");
   endtask : t_regs
   task t_factory;
      rst(8'h00, 8'h00, 4'hf);
      chan_button <= 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         axi_rd(8'h30 + 8'(4 * i), 2'b00);
         check(d, 32'h0000_0010, "factory word");
      end
   endtask : t_factory
   task t_setup;
      rst(8'h00, 8'h00, 4'h2);
      chan_button <= 4'h0;
      switch_bank_one <= 8'h20;
      repeat (4) @(posedge aclk);
      check(setup_mode, 1'b1, "setup entry");
      check(bar_graph, 16'h0010, "stored word shown");
      chan_button <= 4'h2;
      repeat (4) @(posedge aclk);
      check(bar_graph, 16'h0020, "saved word shown");
      chan_button <= 4'h0;
      @(posedge aclk);
      chan_button <= 4'h1;
      repeat (4) @(posedge aclk);
      check(bar_graph, 16'h0010, "other channel shown");
      chan_button <= 4'h0;
      rst(8'h00, 8'h00, 4'h0);
      axi_rd(8'h34, 2'b00);
      check(d, 32'h0000_0020, "word kept over reset");
   endtask : t_setup
   task t_relay;
      int n;
      rst(8'h03, 8'h00, 4'h0);
      vehicle_detect <= 4'h1;
      repeat (5) @(posedge aclk);
      check(relay_line[0], 1'b0, "presence active");
      vehicle_detect <= 4'h0;
      repeat (5) @(posedge aclk);
      check(relay_line[0], 1'b1, "idle released");
      vehicle_detect <= 4'h2;
      n = 0;
      while (!relay_oe[1] && n < 10)
      begin
         @(posedge aclk);
         n++;
      end
      n = 0;
      while (relay_oe[1])
      begin
         @(posedge aclk);
         n++;
      end
      check(n >= 499 * MS && n <= 500 * MS + 4, 1'b1, "long pulse length");
      repeat (10) @(posedge aclk);
      check(relay_oe[1], 1'b0, "single pulse");
      vehicle_detect <= 4'h0;
      rst(8'h13, 8'h10, 4'h0);
      pass_abandon <= 4'h1;
      @(posedge aclk);
      pass_abandon <= 4'h0;
      repeat (3) @(posedge aclk);
      check(relay_oe[0], 1'b1, "reversal pulse");
   endtask : t_relay
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      aclk = 0;
      aresetn = 0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, pass_abandon} = '0;
      {switch_bank_one, switch_bank_two, chan_button, vehicle_detect} = '0;
      {fails, n_tests, cyc} = '0;
      t_general;
      t_regs;
      t_factory;
      t_setup;
      t_relay;
      end_sim;
   end
endmodule : ldc_top_test
`default_nettype wire
